// ===== design/ssr_pkg.sv
package ssr_pkg;

  // Register widths
  localparam int STB_W = 8;
  localparam int SEV_W = 8;
  localparam int DEV_W = 17;
  localparam int OPE_W = 17;

  // Status byte bit positions
  localparam int STB_MEAS = 0;
  localparam int STB_CMDF = 1;
  localparam int STB_DEVS = 3;
  localparam int STB_MAV  = 4;
  localparam int STB_STDS = 5;
  localparam int STB_RQS  = 6;
  localparam int STB_OPS  = 7;

  // Standard event bit positions
  localparam int SEV_OPC = 0;
  localparam int SEV_DDE = 3;
  localparam int SEV_EXE = 4;
  localparam int SEV_CME = 5;

  // Device event bit positions
  localparam int DEV_HIGH = 0;
  localparam int DEV_LOW  = 1;
  localparam int DEV_PASS = 2;
  localparam int DEV_KEY  = 3;

  // Operation event bit positions
  localparam int OPE_CAL = 0;
  localparam int OPE_MEM = 1;

  // Bits that may ever be set
  localparam logic [STB_W-1:0] STB_USED = 8'hFB;
  localparam logic [SEV_W-1:0] SEV_USED = 8'h39;
  localparam logic [DEV_W-1:0] DEV_USED = 17'h0000F;
  localparam logic [OPE_W-1:0] OPE_USED = 17'h00003;

  // Reset values
  localparam logic [STB_W-1:0] STB_RST = 8'h00;
  localparam logic [STB_W-1:0] SRE_RST = 8'h03;
  localparam logic [SEV_W-1:0] SEV_RST = 8'h00;
  localparam logic [DEV_W-1:0] DEV_RST = 17'h00000;
  localparam logic [OPE_W-1:0] OPE_RST = 17'h00000;

  // Event pulses from the instrument core
  typedef struct packed {
    logic meas_done;
    logic data_read;
    logic cmd_fault;
    logic cmd_ok;
    logic opc_cmd;
    logic ops_idle;
    logic dev_error;
    logic exec_error;
    logic cmp_high;
    logic cmp_low;
    logic cmp_pass;
    logic srq_key;
    logic cal_start;
    logic cal_end;
    logic mem_full;
  } ssr_event_s;

  // Host commands and queries, one-cycle pulses
  typedef struct packed {
    logic clear_status;
    logic serial_poll;
    logic stb_query;
    logic std_query;
    logic dev_query;
    logic op_query;
  } ssr_cmd_s;

  // Enable mask write strobes and data
  typedef struct packed {
    logic             sre_wr;
    logic             sev_wr;
    logic             dev_wr;
    logic             ope_wr;
    logic [DEV_W-1:0] data;
  } ssr_mask_wr_s;

endpackage

// ===== design/ssr_status_request.sv
`timescale 1ns/1ns
module ssr_status_request
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  // Instrument events and commands
  input  wire ssr_pkg::ssr_event_s      events,
  input  wire ssr_pkg::ssr_cmd_s        cmds,
  input  wire ssr_pkg::ssr_mask_wr_s    mask_wr,
  input  wire logic                     out_buf_full,
  // Register views
  output logic [ssr_pkg::STB_W-1:0]     status_byte,
  output logic [ssr_pkg::SEV_W-1:0]     standard_event_flags,
  output logic [ssr_pkg::DEV_W-1:0]     device_event_flags,
  output logic [ssr_pkg::OPE_W-1:0]     operation_event_flags,
  output logic [ssr_pkg::STB_W-1:0]     request_enable_mask,
  output logic [ssr_pkg::SEV_W-1:0]     standard_event_enable_mask,
  output logic [ssr_pkg::DEV_W-1:0]     device_event_enable_mask,
  output logic [ssr_pkg::OPE_W-1:0]     operation_event_enable_mask,
  // Service request line and poll answer
  output logic                          srq_reg,
  output logic [ssr_pkg::STB_W-1:0]     poll_byte_reg
);

  logic [ssr_pkg::STB_W-1:0] stb_reg;
  logic [ssr_pkg::STB_W-1:0] stb_next;
  logic [ssr_pkg::SEV_W-1:0] sev_reg;
  logic [ssr_pkg::SEV_W-1:0] sev_set;
  logic [ssr_pkg::DEV_W-1:0] dev_reg;
  logic [ssr_pkg::DEV_W-1:0] dev_set;
  logic [ssr_pkg::OPE_W-1:0] ope_reg;
  logic [ssr_pkg::OPE_W-1:0] ope_set;
  logic [ssr_pkg::STB_W-1:0] sre_reg;
  logic [ssr_pkg::SEV_W-1:0] seve_reg;
  logic [ssr_pkg::DEV_W-1:0] deve_reg;
  logic [ssr_pkg::OPE_W-1:0] opee_reg;
  logic                      opc_pend_reg;
  logic                      rqs_reg;
  logic                      poll_done_reg;
  logic                      mss_cause;
  logic                      dev_sum_hit;
  logic                      sev_sum_hit;
  logic                      ope_sum_hit;

  // Pending operation-complete request
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      opc_pend_reg <= 1'b0;
    else if (cmds.clear_status)
      opc_pend_reg <= 1'b0;
    else if (events.opc_cmd && !events.ops_idle)
      opc_pend_reg <= 1'b1;
    else if (events.ops_idle)
      opc_pend_reg <= 1'b0;
  end

  // Standard event set terms
  always_comb
  begin
    sev_set = '0;
    sev_set[ssr_pkg::SEV_OPC] = (events.opc_cmd || opc_pend_reg) && events.ops_idle;
    sev_set[ssr_pkg::SEV_DDE] = events.dev_error;
    sev_set[ssr_pkg::SEV_EXE] = events.exec_error;
    sev_set[ssr_pkg::SEV_CME] = events.cmd_fault;
  end

  // Device and operation event set terms
  always_comb
  begin
    dev_set = '0;
    dev_set[ssr_pkg::DEV_HIGH] = events.cmp_high;
    dev_set[ssr_pkg::DEV_LOW]  = events.cmp_low;
    dev_set[ssr_pkg::DEV_PASS] = events.cmp_pass;
    dev_set[ssr_pkg::DEV_KEY]  = events.srq_key;
    ope_set = '0;
    ope_set[ssr_pkg::OPE_CAL] = events.cal_end;
    ope_set[ssr_pkg::OPE_MEM] = events.mem_full;
  end

  // Standard event register; set beats clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      sev_reg <= ssr_pkg::SEV_RST;
    else if (cmds.clear_status || cmds.std_query)
      sev_reg <= sev_set & ssr_pkg::SEV_USED;
    else
      sev_reg <= (sev_reg | sev_set) & ssr_pkg::SEV_USED;
  end

  // Device event register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      dev_reg <= ssr_pkg::DEV_RST;
    else if (cmds.clear_status || cmds.dev_query)
      dev_reg <= dev_set & ssr_pkg::DEV_USED;
    else
      dev_reg <= (dev_reg | dev_set) & ssr_pkg::DEV_USED;
  end

  // Operation event register; calibration start drops calibration done
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      ope_reg <= ssr_pkg::OPE_RST;
    else if (cmds.clear_status || cmds.op_query)
      ope_reg <= ope_set & ssr_pkg::OPE_USED;
    else
    begin
      ope_reg <= (ope_reg | ope_set) & ssr_pkg::OPE_USED;
      if (events.cal_start && !events.cal_end)
        ope_reg[ssr_pkg::OPE_CAL] <= 1'b0;
    end
  end

  // Enable mask registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sre_reg  <= ssr_pkg::SRE_RST;
      seve_reg <= ssr_pkg::SEV_RST;
      deve_reg <= ssr_pkg::DEV_RST;
      opee_reg <= ssr_pkg::OPE_RST;
    end
    else
    begin
      if (mask_wr.sre_wr)
        sre_reg <= mask_wr.data[ssr_pkg::STB_W-1:0];
      if (mask_wr.sev_wr)
        seve_reg <= mask_wr.data[ssr_pkg::SEV_W-1:0];
      if (mask_wr.dev_wr)
        deve_reg <= mask_wr.data;
      if (mask_wr.ope_wr)
        opee_reg <= mask_wr.data;
    end
  end

  // Summary hits from newly set enabled events
  assign sev_sum_hit = |(sev_set & seve_reg);
  assign dev_sum_hit = |(dev_set & deve_reg);
  assign ope_sum_hit = |(ope_set & opee_reg);

  // Status byte next value, bit 6 excluded
  always_comb
  begin
    stb_next = stb_reg;
    if (cmds.clear_status)
      stb_next = '0;
    if (events.data_read)
      stb_next[ssr_pkg::STB_MEAS] = 1'b0;
    if (events.meas_done)
      stb_next[ssr_pkg::STB_MEAS] = 1'b1;
    if (events.cmd_ok)
      stb_next[ssr_pkg::STB_CMDF] = 1'b0;
    if (events.cmd_fault)
      stb_next[ssr_pkg::STB_CMDF] = 1'b1;
    if (cmds.dev_query)
      stb_next[ssr_pkg::STB_DEVS] = 1'b0;
    if (dev_sum_hit)
      stb_next[ssr_pkg::STB_DEVS] = 1'b1;
    if (cmds.std_query)
      stb_next[ssr_pkg::STB_STDS] = 1'b0;
    if (sev_sum_hit)
      stb_next[ssr_pkg::STB_STDS] = 1'b1;
    if (cmds.op_query)
      stb_next[ssr_pkg::STB_OPS] = 1'b0;
    if (ope_sum_hit)
      stb_next[ssr_pkg::STB_OPS] = 1'b1;
    stb_next[ssr_pkg::STB_MAV] = out_buf_full;
    stb_next[ssr_pkg::STB_RQS] = 1'b0;
    stb_next = stb_next & ssr_pkg::STB_USED;
  end

  // Status byte storage
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      stb_reg <= ssr_pkg::STB_RST;
    else
      stb_reg <= stb_next;
  end

  // Master summary from enabled causes
  assign mss_cause = |(stb_reg & sre_reg & ssr_pkg::STB_USED);

  // Poll served flag; holds off a fresh request until the causes have gone
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      poll_done_reg <= 1'b0;
    else if (!mss_cause)
      poll_done_reg <= 1'b0;
    else if (cmds.serial_poll)
      poll_done_reg <= 1'b1;
  end

  // Request bit: rises with a new cause, falls on poll or when causes vanish
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rqs_reg <= 1'b0;
    else if (!mss_cause || cmds.serial_poll)
      rqs_reg <= 1'b0;
    else if (!rqs_reg && !poll_done_reg && mss_cause && !cmds.stb_query)
      rqs_reg <= 1'b1;
  end

  // Register views and request line
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_byte                 <= ssr_pkg::STB_RST;
      standard_event_flags        <= ssr_pkg::SEV_RST;
      device_event_flags          <= ssr_pkg::DEV_RST;
      operation_event_flags       <= ssr_pkg::OPE_RST;
      request_enable_mask         <= ssr_pkg::SRE_RST;
      standard_event_enable_mask  <= ssr_pkg::SEV_RST;
      device_event_enable_mask    <= ssr_pkg::DEV_RST;
      operation_event_enable_mask <= ssr_pkg::OPE_RST;
      srq_reg                     <= 1'b0;
      poll_byte_reg               <= ssr_pkg::STB_RST;
    end
    else
    begin
      status_byte                 <= stb_reg | ({7'h00, mss_cause} << ssr_pkg::STB_RQS);
      standard_event_flags        <= sev_reg;
      device_event_flags          <= dev_reg;
      operation_event_flags       <= ope_reg;
      request_enable_mask         <= sre_reg;
      standard_event_enable_mask  <= seve_reg;
      device_event_enable_mask    <= deve_reg;
      operation_event_enable_mask <= opee_reg;
      srq_reg                     <= rqs_reg && !cmds.serial_poll;
      if (cmds.serial_poll)
        poll_byte_reg <= stb_reg | ({7'h00, rqs_reg} << ssr_pkg::STB_RQS);
    end
  end

  // Checks
  AST_MEAS_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.meas_done |=> stb_reg[ssr_pkg::STB_MEAS])
    else $error("measurement done bit not set");

  AST_CMDF_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    (events.cmd_ok && !events.cmd_fault) |=> !stb_reg[ssr_pkg::STB_CMDF])
    else $error("command fault bit not cleared");

  AST_MAV_FOLLOW: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 stb_reg[ssr_pkg::STB_MAV] == $past(out_buf_full))
    else $error("message available bit wrong");

  AST_STD_SUM: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.dev_error && seve_reg[ssr_pkg::SEV_DDE] |=> stb_reg[ssr_pkg::STB_STDS] ##1 status_byte[ssr_pkg::STB_STDS])
    else $error("standard summary not set");

  AST_SRQ_MASK: assert property (@(posedge core_clk) disable iff (!reset_n)
    !mss_cause |=> !rqs_reg)
    else $error("request raised without enabled cause");

  AST_POLL_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmds.serial_poll |=> !rqs_reg ##0 !srq_reg)
    else $error("serial poll did not clear request");

  AST_CLS_EVT: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmds.clear_status && !events.cmp_high && !events.cmp_low && !events.cmp_pass && !events.srq_key)
      |=> dev_reg == ssr_pkg::DEV_RST)
    else $error("device events not cleared");

  AST_UNUSED_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n)
    ((stb_reg & ~ssr_pkg::STB_USED) == '0) && ((ope_reg & ~ssr_pkg::OPE_USED) == '0))
    else $error("unused bit set");

  AST_CAL_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.cal_start && !events.cal_end && !events.mem_full |=> !ope_reg[ssr_pkg::OPE_CAL])
    else $error("calibration done not cleared");

  AST_MEAS_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.data_read && !events.meas_done |=> !stb_reg[ssr_pkg::STB_MEAS])
    else $error("measurement done bit not cleared");

  AST_CMDF_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.cmd_fault |=> stb_reg[ssr_pkg::STB_CMDF])
    else $error("command fault bit not set");

  AST_DEVS_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.cmp_high && deve_reg[ssr_pkg::DEV_HIGH] |=> stb_reg[ssr_pkg::STB_DEVS])
    else $error("device summary not set");

  AST_DEVS_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmds.dev_query && !dev_sum_hit |=> !stb_reg[ssr_pkg::STB_DEVS])
    else $error("device summary not cleared");

  AST_STDS_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmds.std_query && !sev_sum_hit |=> !stb_reg[ssr_pkg::STB_STDS])
    else $error("standard summary not cleared");

  AST_OPS_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.mem_full && opee_reg[ssr_pkg::OPE_MEM] |=> stb_reg[ssr_pkg::STB_OPS])
    else $error("operation summary not set");

  AST_OPS_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmds.op_query && !ope_sum_hit |=> !stb_reg[ssr_pkg::STB_OPS])
    else $error("operation summary not cleared");

  AST_CLS_STB: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmds.clear_status && !events.meas_done && !events.cmd_fault && !dev_sum_hit && !sev_sum_hit && !ope_sum_hit
      |=> stb_reg == ({7'h00, $past(out_buf_full)} << ssr_pkg::STB_MAV))
    else $error("clear status left status bits");

  AST_SRQ_CAUSE: assert property (@(posedge core_clk) disable iff (!reset_n)
    srq_reg |-> $past(mss_cause, 2))
    else $error("request line without enabled cause");

  AST_RQS_RISE: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(mss_cause) && !cmds.serial_poll && !cmds.stb_query |=> rqs_reg)
    else $error("new cause raised no request");

  AST_POLL_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmds.serial_poll |=> !srq_reg [*2])
    else $error("request line back too soon after poll");

  AST_POLL_BYTE: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmds.serial_poll |=> poll_byte_reg[ssr_pkg::STB_RQS] == $past(rqs_reg))
    else $error("poll byte request bit wrong");

  AST_OPC_ONLY: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(sev_reg[ssr_pkg::SEV_OPC]) |-> $past(events.opc_cmd || opc_pend_reg))
    else $error("operation complete without command");

  AST_DDE_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.dev_error |=> sev_reg[ssr_pkg::SEV_DDE])
    else $error("device error bit not set");

  AST_EXE_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.exec_error |=> sev_reg[ssr_pkg::SEV_EXE])
    else $error("execution error bit not set");

  AST_CME_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.cmd_fault |=> sev_reg[ssr_pkg::SEV_CME])
    else $error("command error bit not set");

  AST_CMP_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.cmp_pass |=> dev_reg[ssr_pkg::DEV_PASS])
    else $error("comparator pass bit not set");

  AST_KEY_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.srq_key |=> dev_reg[ssr_pkg::DEV_KEY])
    else $error("request key bit not set");

  AST_MEM_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    events.mem_full |=> ope_reg[ssr_pkg::OPE_MEM])
    else $error("memory full bit not set");

  AST_SEV_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmds.std_query && (sev_set == '0) |=> sev_reg == ssr_pkg::SEV_RST)
    else $error("standard events not cleared by query");

endmodule

// ===== verif/ssr_host_model.sv
`timescale 1ns/1ns
// Bus controller stand-in: answers a service request with a serial poll
module ssr_host_model
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Request line and reaction time in cycles
  input  wire logic       srq_reg,
  input  wire logic [3:0] poll_gap,
  // Poll pulse towards the device
  output logic            serial_poll
);
  int wait_cnt;

  // Waits poll_gap cycles of a standing request, polls, then holds off
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serial_poll <= 1'b0;
      wait_cnt    <= 0;
    end
    else if (serial_poll)
    begin
      serial_poll <= 1'b0;
      wait_cnt    <= -4;                 // Let the request line settle
    end
    else if (wait_cnt < 0)
      wait_cnt <= wait_cnt + 1;
    else if (!srq_reg)
      wait_cnt <= 0;
    else if (wait_cnt >= int'(poll_gap))
      serial_poll <= 1'b1;
    else
      wait_cnt <= wait_cnt + 1;
  end
endmodule

// ===== verif/test_status_service_request.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_status_service_request;
  typedef struct packed
  {
    logic [14:0] ev;
    logic [7:0]  stb;
    logic [7:0]  stb_m;
    logic [7:0]  sev;
    logic [16:0] dev;
    logic [16:0] ope;
  } ssr_row_s;
  // Event pulse, expected views
  localparam ssr_row_s ROWS [10] = '{
    '{15'h4000, 8'h41, 8'hFF, 8'h00, 17'h0, 17'h0}, '{15'h0400, 8'h60, 8'hFF, 8'h01, 17'h0, 17'h0},
    '{15'h0100, 8'h60, 8'hFF, 8'h08, 17'h0, 17'h0}, '{15'h0080, 8'h60, 8'hFD, 8'h10, 17'h0, 17'h0},
    '{15'h0040, 8'h48, 8'hFF, 8'h00, 17'h1, 17'h0}, '{15'h0020, 8'h48, 8'hFF, 8'h00, 17'h2, 17'h0},
    '{15'h0010, 8'h48, 8'hFF, 8'h00, 17'h4, 17'h0}, '{15'h0008, 8'h48, 8'hFF, 8'h00, 17'h8, 17'h0},
    '{15'h0002, 8'hC0, 8'hFF, 8'h00, 17'h0, 17'h1}, '{15'h0001, 8'hC0, 8'hFF, 8'h00, 17'h0, 17'h2}};
  logic        core_clk;
  logic        reset_n;
  logic        out_buf_full;
  logic        idle_lvl;
  logic        poll;
  logic [3:0]  poll_gap;
  logic [14:0] ev_v;
  logic [5:0]  cmd_v;
  logic [20:0] mw_v;
  logic [7:0]  status_byte;
  logic [7:0]  sev_flags;
  logic [16:0] dev_flags;
  logic [16:0] ope_flags;
  logic        srq_reg;
  logic [7:0]  poll_byte_reg;
  logic [7:0]  sre_view;
  logic [7:0]  seve_view;
  logic [16:0] deve_view;
  logic [16:0] opee_view;
  int          n_mismatch;
  int          n_checks;
  int          cycles;

  ssr_status_request dut (.core_clk(core_clk), .reset_n(reset_n),
    .events(ssr_pkg::ssr_event_s'(ev_v | {5'h00, idle_lvl, 9'h000})),
    .cmds(ssr_pkg::ssr_cmd_s'({cmd_v[5], poll, cmd_v[3:0]})), .mask_wr(ssr_pkg::ssr_mask_wr_s'(mw_v)),
    .out_buf_full(out_buf_full), .status_byte(status_byte), .standard_event_flags(sev_flags),
    .device_event_flags(dev_flags), .operation_event_flags(ope_flags), .request_enable_mask(sre_view),
    .standard_event_enable_mask(seve_view), .device_event_enable_mask(deve_view),
    .operation_event_enable_mask(opee_view),
    .srq_reg(srq_reg), .poll_byte_reg(poll_byte_reg));
  ssr_host_model host (.core_clk(core_clk), .reset_n(reset_n), .srq_reg(srq_reg), .poll_gap(poll_gap),
    .serial_poll(poll));

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // Verdict
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One-cycle pulse on events (0), commands (1) or mask writes (2), then settle
  task automatic drive(input int which, input logic [20:0] v);
    @(posedge core_clk);
    if (which == 0) ev_v <= v[14:0];
    else if (which == 1) cmd_v <= v[5:0];
    else mw_v <= v;
    @(posedge core_clk);
    ev_v  <= '0;
    cmd_v <= '0;
    mw_v  <= '0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // Reset views
  task automatic chk_reset();
    `CHK({status_byte, sev_flags, dev_flags, ope_flags, srq_reg}, 51'h0)
    `CHK({sre_view, seve_view, deve_view, opee_view}, {8'h03, 42'h0})
  endtask

  // Main sequence
  initial
  begin
    reset_n = 1'b0; out_buf_full = 1'b0; idle_lvl = 1'b1; poll_gap = 4'h0;
    ev_v = '0; cmd_v = '0; mw_v = '0; n_mismatch = 0; n_checks = 0; cycles = 0;
    repeat (12) @(posedge core_clk);
    #1;
    chk_reset();
    @(posedge core_clk);
    reset_n <= 1'b1;
    $display("test reset done");
    drive(2, {4'h8, 17'h000FF}); drive(2, {4'h4, 17'h000FF});
    drive(2, {4'h2, 17'h1FFFF}); drive(2, {4'h1, 17'h1FFFF});
    `CHK({sre_view, seve_view, deve_view, opee_view}, {8'hFF, 8'hFF, 17'h1FFFF, 17'h1FFFF})
    foreach (ROWS[i])
    begin
      drive(1, 21'h20);
      drive(0, ROWS[i].ev);
      `CHK(status_byte & ROWS[i].stb_m, ROWS[i].stb)
      `CHK({sev_flags, dev_flags, ope_flags}, {ROWS[i].sev, ROWS[i].dev, ROWS[i].ope})
    end
    $display("test event table done");
    drive(2, {4'h8, 17'h00001});
    for (int g = 0; g <= 5; g += 5)
    begin
      poll_gap <= 4'(g);
      drive(1, 21'h20);
      drive(0, 15'h4000);
      `CHK(srq_reg, 1'b1)
      for (int k = 0; k < 20 && srq_reg !== 1'b0; k++) @(negedge core_clk);
      repeat (6) @(negedge core_clk);
      `CHK({srq_reg, poll_byte_reg[6], status_byte}, 10'h141)
      drive(0, 15'h2000);
      `CHK(status_byte, 8'h00)
    end
    drive(0, 15'h0040);
    `CHK({srq_reg, status_byte}, 9'h008)
    $display("test request and poll done");
    drive(2, {4'h8, 17'h000FF});
    drive(1, 21'h20);
    drive(0, 15'h0442);
    `CHK(status_byte, 8'hE8)
    drive(1, 21'h04);
    `CHK({status_byte, sev_flags}, 16'hC800)
    drive(1, 21'h02);
    `CHK({status_byte, dev_flags}, 25'h1800000)
    drive(1, 21'h01);
    `CHK({status_byte, ope_flags}, 25'h0)
    $display("test queries done");
    out_buf_full <= 1'b1;
    drive(0, 15'h0000);
    `CHK(status_byte, 8'h50)
    drive(1, 21'h20);
    `CHK(status_byte, 8'h50)
    out_buf_full <= 1'b0;
    drive(0, 15'h0000);
    `CHK(status_byte, 8'h00)
    drive(0, 15'h1000);
    `CHK(status_byte[1], 1'b1)
    drive(0, 15'h0800);
    `CHK(status_byte[1], 1'b0)
    drive(0, 15'h0002);
    drive(0, 15'h0004);
    `CHK(ope_flags, 17'h0)
    drive(1, 21'h20);
    idle_lvl <= 1'b0;
    drive(0, 15'h0400);
    `CHK(sev_flags[0], 1'b0)
    idle_lvl <= 1'b1;
    drive(0, 15'h0000);
    `CHK(sev_flags[0], 1'b1)
    $display("test buffer, fault, calibration and completion done");
    drive(2, {4'h4, 17'h0}); drive(2, {4'h2, 17'h0}); drive(2, {4'h1, 17'h0});
    drive(1, 21'h20);
    drive(0, 15'h05FB);
    `CHK(status_byte & 8'hAC, 8'h00)
    `CHK(sev_flags & ~ssr_pkg::SEV_USED, 8'h00)
    `CHK({dev_flags, ope_flags}, {17'h0000F, 17'h00003})
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk_reset();
    $display("test masked events and second reset done");
    complete_run();
  end
endmodule
